// file: core/csf_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the core only; the package does not include it
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH
`define CSF_OFS_BANK      8'h00
`define CSF_OFS_STATUS    8'h04
`define CSF_OFS_PCL       8'h08
`define CSF_OFS_TABLE_POINTER_LOW      8'h0c
`define CSF_OFS_TABLE_POINTER_HIGH      8'h10
`define CSF_OFS_TABLE_READ_HIGH_BYTE      8'h14
`define CSF_OFS_ACC       8'h18
`define CSF_BIT_CARRY     0
`define CSF_BIT_HALF      1
`define CSF_BIT_ZERO      2
`define CSF_BIT_RANGE     3
`define CSF_BIT_SLEEP     4
`define CSF_BIT_WDOG      5
`define CSF_BIT_CHAIN     6
`define CSF_BIT_SIGNED    7
`define CSF_BANK_RST      1'b0
`define CSF_PCL_DUMMY     2'd1
`endif

// file: core/csf_pkg.sv
// Purpose: Types shared by the status and bank register core
// Assumes: Nothing beyond the constant header
// Notes:   Opcode enum selects how the flags update
package csf_pkg;
    typedef enum logic [3:0] {
        CSF_OP_NONE  = 4'h0,
        CSF_OP_ADD   = 4'h1,
        CSF_OP_ADC   = 4'h2,
        CSF_OP_SUB   = 4'h3,
        CSF_OP_SBC   = 4'h4,
        CSF_OP_LOGIC = 4'h5,
        CSF_OP_RLC   = 4'h6,
        CSF_OP_RRC   = 4'h7,
        CSF_OP_MOVA  = 4'h8,
        CSF_OP_MOVM  = 4'h9,
        CSF_OP_TABRD = 4'ha
    } csf_op_t;

    typedef enum logic [1:0] {
        CSF_PC_IDLE  = 2'b00,
        CSF_PC_DUMMY = 2'b01
    } csf_pcst_t;

    typedef struct packed {
        logic [7:0]  flags;
        logic        bank;
        logic [7:0]  table_pointer_low;
        logic [7:0]  table_pointer_high;
        logic [7:0]  table_read_high_byte;
        logic [7:0]  acc;
        logic [12:0] pc;
        csf_pcst_t   pcst;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  wdata;
        logic        wvalid;
        logic [15:0] taddr;
        logic        tvalid;
    } csf_state_t;
endpackage

// file: core/csf_core.sv
// Purpose: Status flags, bank pointer, pc low byte, table read and accumulator
// Assumes: Execution logic on the same clock drives op, operands and strobes
// Notes:   APB slave answers one cycle after the setup phase
//
// Summary of operation
// - Bank pointer bit 0 picks program bank 0 or 1, resets to 0.
// - Bank pointer bits 7 to 1 always read as zero.
// - Jump and call targets take the bank currently selected.
// - Writing pc low byte loads pc bits 7:0 and adds a dummy cycle.
// - Table read fetches word at pointer pair; high byte to latch.
// - No register to register move; data passes via accumulator.
// - Status writes change arithmetic flags, never watchdog or sleep flags.
// - Watchdog flag set by time-out, cleared by power-up, clear or sleep.
// - Sleep flag set by sleep, cleared by power-up or watchdog clear.
// - Carry set on add carry or subtract no-borrow; rotates update it.
// - Half carry set on low nibble carry or no nibble borrow.
// - Zero flag set when an arithmetic or logic result is zero.
// - Overflow set when carry into msb differs from carry out.
// - Signed flag equals overflow xor result msb.
// - Plain subtract copies zero into the chained zero flag.
// - Subtract with borrow ands chained zero with zero; others keep it.
// - Status is never saved automatically on call or interrupt.
`timescale 1ns/1ps
`include "csf_regs.svh"

module csf_core #(
    parameter int PC_W = 13
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Execution interface
    input  wire logic [3:0]  op,
    input  wire logic [7:0]  opa,
    input  wire logic [7:0]  opb,
    input  wire logic [7:0]  mem_data,
    input  wire logic        far_form,
    input  wire logic        branch,
    input  wire logic [11:0] branch_addr,
    input  wire logic        pc_step,
    input  wire logic        wdt_timeout,
    input  wire logic        watchdog_clear_instr,
    input  wire logic        sleep_instr,
    input  wire logic [15:0] prog_word,
    // Results
    output logic [7:0]       status_flags,
    output logic             program_bank_select,
    output logic [PC_W-1:0]  pc,
    output logic             pc_dummy,
    output logic [7:0]       acc,
    output logic [7:0]       mem_wdata,
    output logic             mem_we,
    output logic [15:0]      table_addr,
    output logic             table_rd
);
    // Only a 13-bit counter with bit 12 as bank is built
    if (PC_W != 13) begin : g_pc_w_chk
        $error("csf_core supports PC_W of 13 only");
    end

    csf_pkg::csf_state_t s_q;
    csf_pkg::csf_state_t s_d;

    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [7:0]  res;
    logic        cin;
    logic        c7;
    logic [7:0]  low7;
    logic        arith;
    logic        setup;
    logic [7:0]  sw_status;
    csf_pkg::csf_op_t opc;

    assign opc = csf_pkg::csf_op_t'(op);
    assign setup = psel && !penable;

    // Next state
    always_comb begin
        s_d = s_q;
        sum = 9'h000;
        nib = 5'h00;
        res = 8'h00;
        cin = 1'b0;
        c7 = 1'b0;
        low7 = 8'h00;
        arith = 1'b0;
        sw_status = 8'h00;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.wvalid = 1'b0;
        s_d.tvalid = 1'b0;
        // Table word return lands high byte in latch
        if (s_q.tvalid) begin
            s_d.table_read_high_byte = prog_word[15:8];
            s_d.wdata = prog_word[7:0];
            s_d.wvalid = 1'b1;
        end
        // Arithmetic unit; subtraction is a + ~b + carry-in
        unique case (opc)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC: begin
                cin = (opc == csf_pkg::CSF_OP_ADC) &&
                      s_q.flags[`CSF_BIT_CARRY];
                sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
                nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
                // Carry into bit 7 from a sized 8-bit sum of bits 6:0
                low7 = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
                c7 = low7[7];
                arith = 1'b1;
            end
            csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
                cin = (opc == csf_pkg::CSF_OP_SUB) ||
                      s_q.flags[`CSF_BIT_CARRY];
                sum = {1'b0, opa} + {1'b0, ~opb} + {8'h00, cin};
                nib = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + {4'h0, cin};
                // Invert inside the concatenation so no upper ones leak in
                low7 = {1'b0, opa[6:0]} + {1'b0, ~opb[6:0]} + {7'h00, cin};
                c7 = low7[7];
                arith = 1'b1;
            end
            default: ;
        endcase
        if (arith) begin
            res = sum[7:0];
            s_d.flags[`CSF_BIT_CARRY] = sum[8];
            s_d.flags[`CSF_BIT_HALF] = nib[4];
            s_d.flags[`CSF_BIT_ZERO] = (res == 8'h00);
            s_d.flags[`CSF_BIT_RANGE] = c7 ^ sum[8];
            s_d.flags[`CSF_BIT_SIGNED] = (c7 ^ sum[8]) ^ res[7];
            s_d.acc = res;
            if (opc == csf_pkg::CSF_OP_SUB)
                s_d.flags[`CSF_BIT_CHAIN] = (res == 8'h00);
            if (opc == csf_pkg::CSF_OP_SBC)
                s_d.flags[`CSF_BIT_CHAIN] =
                    s_q.flags[`CSF_BIT_CHAIN] & (res == 8'h00);
        end
        // Logic, rotate and transfer operations
        unique case (opc)
            csf_pkg::CSF_OP_LOGIC: begin
                s_d.acc = opa;
                s_d.flags[`CSF_BIT_ZERO] = (opa == 8'h00);
            end
            csf_pkg::CSF_OP_RLC: begin
                s_d.acc = {opa[6:0], s_q.flags[`CSF_BIT_CARRY]};
                s_d.flags[`CSF_BIT_CARRY] = opa[7];
            end
            csf_pkg::CSF_OP_RRC: begin
                s_d.acc = {s_q.flags[`CSF_BIT_CARRY], opa[7:1]};
                s_d.flags[`CSF_BIT_CARRY] = opa[0];
            end
            csf_pkg::CSF_OP_MOVA: s_d.acc = mem_data;
            csf_pkg::CSF_OP_MOVM: begin
                s_d.wdata = s_q.acc;
                s_d.wvalid = 1'b1;
            end
            csf_pkg::CSF_OP_TABRD: begin
                s_d.taddr = {s_q.table_pointer_high, s_q.table_pointer_low};
                s_d.tvalid = 1'b1;
            end
            default: ;
        endcase
        // Far forms are timed the same; with no op the far flag drops the memory write
        if (far_form && opc == csf_pkg::CSF_OP_NONE) s_d.wvalid = 1'b0;
        // Program counter sequencing
        unique case (s_q.pcst)
            csf_pkg::CSF_PC_DUMMY: s_d.pcst = csf_pkg::CSF_PC_IDLE;
            csf_pkg::CSF_PC_IDLE: begin
                if (branch)
                    s_d.pc = {s_q.bank, branch_addr};
                else if (pc_step)
                    s_d.pc = s_q.pc + 13'h0001;
            end
            default: s_d.pcst = csf_pkg::CSF_PC_IDLE;
        endcase
        // APB access phase; answers one cycle after setup
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                `CSF_OFS_BANK:   s_d.prdata[0] = s_q.bank;
                `CSF_OFS_STATUS: s_d.prdata[7:0] = s_q.flags;
                `CSF_OFS_PCL:    s_d.prdata[7:0] = s_q.pc[7:0];
                `CSF_OFS_TABLE_POINTER_LOW:   s_d.prdata[7:0] = s_q.table_pointer_low;
                `CSF_OFS_TABLE_POINTER_HIGH:   s_d.prdata[7:0] = s_q.table_pointer_high;
                `CSF_OFS_TABLE_READ_HIGH_BYTE:   s_d.prdata[7:0] = s_q.table_read_high_byte;
                `CSF_OFS_ACC:    s_d.prdata[7:0] = s_q.acc;
                default:         s_d.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s_q.pready && pwrite) begin
            unique case (paddr)
                `CSF_OFS_BANK: s_d.bank = pwdata[0];
                `CSF_OFS_STATUS: begin
                    sw_status = pwdata[7:0];
                    sw_status[`CSF_BIT_WDOG] = s_d.flags[`CSF_BIT_WDOG];
                    sw_status[`CSF_BIT_SLEEP] = s_d.flags[`CSF_BIT_SLEEP];
                    s_d.flags = sw_status;
                end
                `CSF_OFS_PCL: begin
                    s_d.pc[7:0] = pwdata[7:0];
                    s_d.pcst = csf_pkg::CSF_PC_DUMMY;
                end
                `CSF_OFS_TABLE_POINTER_LOW: s_d.table_pointer_low = pwdata[7:0];
                `CSF_OFS_TABLE_POINTER_HIGH: s_d.table_pointer_high = pwdata[7:0];
                `CSF_OFS_ACC:  s_d.acc = pwdata[7:0];
                default: ;
            endcase
        end
        // System flags: only hardware events touch them; set wins
        if (watchdog_clear_instr || sleep_instr)
            s_d.flags[`CSF_BIT_WDOG] = 1'b0;
        if (wdt_timeout)
            s_d.flags[`CSF_BIT_WDOG] = 1'b1;
        if (watchdog_clear_instr)
            s_d.flags[`CSF_BIT_SLEEP] = 1'b0;
        if (sleep_instr)
            s_d.flags[`CSF_BIT_SLEEP] = 1'b1;
        // Status is never pushed; no stack path exists here
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.bank <= `CSF_BANK_RST;
            s_q.pcst <= csf_pkg::CSF_PC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops; pc_dummy decodes the pc state flop
    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign status_flags = s_q.flags;
    assign program_bank_select = s_q.bank;
    assign pc = s_q.pc;
    assign pc_dummy = (s_q.pcst == csf_pkg::CSF_PC_DUMMY);
    assign acc = s_q.acc;
    assign mem_wdata = s_q.wdata;
    assign mem_we = s_q.wvalid;
    assign table_addr = s_q.taddr;
    assign table_rd = s_q.tvalid;

    // Checks
    bank_reset_a: assert property (@(posedge clk)
        !rst_b |=> !program_bank_select)
        else $error("bank select not cleared by reset");
    bank_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
        pready && paddr == `CSF_OFS_BANK |-> prdata[31:1] == 0)
        else $error("bank upper bits not zero");
    branch_bank_a: assert property (@(posedge clk) disable iff (!rst_b)
        branch && !pc_dummy && !(psel && penable && pwrite)
        |=> pc[12] == $past(program_bank_select))
        else $error("branch left selected bank");
    pcl_dummy_a: assert property (@(posedge clk) disable iff (!rst_b)
        psel && penable && pready && pwrite && paddr == `CSF_OFS_PCL
        |=> pc_dummy ##1 !pc_dummy)
        else $error("pc low write without one dummy cycle");
    table_high_a: assert property (@(posedge clk) disable iff (!rst_b)
        table_rd |=> s_q.table_read_high_byte == $past(prog_word[15:8]))
        else $error("table high byte not latched");
    status_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
        psel && penable && pready && pwrite && paddr == `CSF_OFS_STATUS
        && !wdt_timeout && !watchdog_clear_instr && !sleep_instr
        |=> $stable(status_flags[5:4]))
        else $error("software write changed system flags");
    wdog_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        wdt_timeout |=> status_flags[`CSF_BIT_WDOG])
        else $error("watchdog flag not set");
    sleep_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        watchdog_clear_instr && !sleep_instr
        |=> !status_flags[`CSF_BIT_SLEEP])
        else $error("sleep flag not cleared");
    signed_xor_a: assert property (@(posedge clk) disable iff (!rst_b)
        arith && !(psel && penable && pwrite) |=> status_flags[7] ==
        (status_flags[3] ^ acc[7]))
        else $error("signed flag mismatch");
    chain_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_LOGIC && !(psel && penable && pwrite)
        |=> $stable(status_flags[6]))
        else $error("chained zero changed");
    cov_sbc_c: cover property (@(posedge clk) opc == csf_pkg::CSF_OP_SBC);
    cov_pcl_c: cover property (@(posedge clk) pc_dummy);
    cov_tab_c: cover property (@(posedge clk) table_rd);
    cov_wdog_c: cover property (@(posedge clk) wdt_timeout);
    cov_sub_c: cover property (@(posedge clk) opc == csf_pkg::CSF_OP_SUB);

    // Arithmetic and rotate results checked against independent expressions
    add_carry_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_ADD && !(psel && penable && pwrite)
        |=> {status_flags[0], acc} == $past({1'b0, opa} + {1'b0, opb}))
        else $error("add carry or result wrong");
    zero_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        arith && !(psel && penable && pwrite)
        |=> status_flags[2] == (acc == 8'h00))
        else $error("zero flag wrong");
    range_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_ADD && !(psel && penable && pwrite)
        |=> status_flags[3] == ($past(opa[7] == opb[7]) &&
        acc[7] != $past(opa[7])))
        else $error("overflow flag wrong");
    rotate_carry_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_RLC && !(psel && penable && pwrite)
        |=> status_flags[0] == $past(opa[7]))
        else $error("rotate carry wrong");

    // Chained zero flag
    sub_chain_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_SUB && !(psel && penable && pwrite)
        |=> status_flags[6] == status_flags[2])
        else $error("chained zero not copied");
    sbc_chain_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_SBC && !(psel && penable && pwrite)
        |=> status_flags[6] == ($past(status_flags[6]) && status_flags[2]))
        else $error("chained zero not anded");

    // System flags
    wdog_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (watchdog_clear_instr || sleep_instr) && !wdt_timeout
        |=> !status_flags[`CSF_BIT_WDOG])
        else $error("watchdog flag not cleared");
    sleep_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        sleep_instr |=> status_flags[`CSF_BIT_SLEEP])
        else $error("sleep flag not set");
    reset_sys_a: assert property (@(posedge clk)
        !rst_b |=> status_flags[5:4] == 2'b00)
        else $error("system flags not cleared by reset");

    // Transfers and program counter
    mova_acc_a: assert property (@(posedge clk) disable iff (!rst_b)
        opc == csf_pkg::CSF_OP_MOVA && !(psel && penable && pwrite)
        |=> acc == $past(mem_data))
        else $error("move to accumulator wrong");
    table_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        table_rd |=> mem_we && mem_wdata == $past(prog_word[7:0]))
        else $error("table low byte not written");
    pcl_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        psel && penable && pready && pwrite && paddr == `CSF_OFS_PCL
        |=> pc[7:0] == $past(pwdata[7:0]))
        else $error("pc low byte not loaded");
endmodule

// file: verif/csf_prog_mem.sv
// Purpose: Program memory stand-in answering table reads
// Assumes: Word stands while the read strobe is high
// Notes:   Between reads the word output toggles every cycle
`timescale 1ns/1ps

module csf_prog_mem (
    // Clock
    input  wire logic        clk,
    // Table read request
    input  wire logic        table_rd,
    input  wire logic [15:0] table_addr,
    // Returned word
    output logic [15:0]      prog_word
);
    logic [15:0] idle_q = 16'h0f0f;

    // Idle word toggles so stale data is never left standing
    always @(posedge clk) begin
        idle_q <= ~idle_q;
    end

    // Contents follow the address while the strobe stands
    assign prog_word = table_rd ? {table_addr[7:0] ^ 8'h3c,
                                   table_addr[15:8] ^ 8'h5a} : idle_q;
endmodule

// file: verif/test_cpu_status_flags_and_bank_regs.sv
// Purpose: Self-checking bench for the status flag and bank register core
// Assumes: Flags start at zero after reset
// Notes:   Random add and subtract traffic is checked against a flag model
`timescale 1ns/1ps

module test_cpu_status_flags_and_bank_regs;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  op = 4'h0;
    logic [7:0]  opa = 8'h00;
    logic [7:0]  opb = 8'h00;
    logic [7:0]  mem_data = 8'h00;
    logic        branch = 1'b0;
    logic [11:0] branch_addr = 12'h000;
    logic [2:0]  ev = 3'b000;
    logic        pready, prdata_err, program_bank_select, pc_dummy;
    logic        mem_we, table_rd, er;
    logic [31:0] prdata, rd;
    logic [15:0] prog_word, table_addr;
    logic [7:0]  status_flags, acc, mem_wdata, last_wr, ef;
    logic [12:0] pc;
    int          error_cnt = 0, tests_run = 0, dum_cnt = 0, seed_v;

    // Clock of 25 ns period
    initial forever #12.5 clk = ~clk;

    csf_core u_csf_core (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr(prdata_err), .op, .opa, .opb,
        .mem_data, .far_form(1'b0), .branch, .branch_addr,
        .pc_step(1'b0), .wdt_timeout(ev[2]),
        .watchdog_clear_instr(ev[1]), .sleep_instr(ev[0]), .prog_word,
        .status_flags, .program_bank_select, .pc, .pc_dummy, .acc,
        .mem_wdata, .mem_we, .table_addr, .table_rd);
    csf_prog_mem u_csf_prog_mem (.clk, .table_rd, .table_addr, .prog_word);

    // Capture memory writes and count dummy cycles
    always @(posedge clk) begin
        if (mem_we === 1'b1) last_wr <= mem_wdata;
        if (pc_dummy === 1'b1) dum_cnt <= dum_cnt + 1;
    end

    // Expected flags and result of add and subtract forms
    function automatic logic [15:0] alu(input logic [3:0] o,
        input logic [7:0] a, b, f);
        logic [7:0] bb, t7;
        logic [4:0] t4;
        logic [8:0] s;
        logic       ci, z;
        bb = (o >= 4'h3) ? ~b : b;
        ci = (o == 4'h1) ? 1'b0 : (o == 4'h3) ? 1'b1 : f[0];
        t7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h0, ci};
        t4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        s = {1'b0, a} + {1'b0, bb} + {8'h0, ci};
        z = (s[7:0] == 8'h00);
        f[0] = s[8];
        f[1] = t4[4];
        f[2] = z;
        f[3] = t7[7] ^ s[8];
        f[7] = f[3] ^ s[7];
        if (o == 4'h3) f[6] = z;
        else if (o == 4'h4) f[6] = f[6] & z;
        return {f, s[7:0]};
    endfunction

    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        er = prdata_err;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic exec(input logic [3:0] o, input logic [7:0] a, b);
        @(posedge clk);
        op <= o;
        opa <= a;
        opb <= b;
        @(posedge clk);
        op <= 4'h0;
        #1;
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 3'b000;
        #1;
    endtask

    task automatic run_op(input logic [3:0] o, input logic [7:0] a, b);
        logic [15:0] e;
        e = alu(o, a, b, ef);
        exec(o, a, b);
        chk(status_flags, e[15:8]);
        chk(acc, e[7:0]);
        ef = e[15:8];
    endtask

    // Hang guard
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end

    // Main sequence
    initial begin
        seed_v = $urandom(32'hfea8);
        ef = 8'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk(status_flags, 8'h00);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h00, {24'hffffff, 7'h7f, k[0]});
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {31'h0, k[0]});
            @(posedge clk);
            branch <= 1'b1;
            branch_addr <= 12'h5a3;
            @(posedge clk);
            branch <= 1'b0;
            #1;
            chk(pc, {k[0], 12'h5a3});
            chk(status_flags, ef);
        end
        apb(1'b1, 8'h08, 32'h000000c6);
        chk(pc, {5'h15, 8'hc6});
        apb(1'b1, 8'h0c, 32'h34);
        apb(1'b1, 8'h10, 32'h12);
        exec(4'ha, 8'h00, 8'h00);
        chk({table_rd, table_addr}, 17'h11234);
        repeat (3) @(posedge clk);
        #1;
        chk(last_wr, 8'h12 ^ 8'h5a);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h34 ^ 32'h3c);
        chk(dum_cnt, 1);
        mem_data <= 8'h6e;
        exec(4'h8, 8'h00, 8'h00);
        chk(acc, 8'h6e);
        exec(4'h9, 8'h00, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk(last_wr, 8'h6e);
        run_op(4'h1, 8'hff, 8'h01);
        run_op(4'h1, 8'h7f, 8'h01);
        run_op(4'h3, 8'h44, 8'h44);
        run_op(4'h4, 8'h00, 8'h00);
        run_op(4'h3, 8'h10, 8'h21);
        run_op(4'h4, 8'h05, 8'h05);
        repeat (60) run_op(4'(1 + $urandom % 4), 8'($urandom), 8'($urandom));
        exec(4'h5, 8'h00, 8'h00);
        chk(status_flags[2], 1'b1);
        exec(4'h5, 8'h80, 8'h00);
        chk(status_flags[2], 1'b0);
        exec(4'h6, 8'h80, 8'h80);
        chk(status_flags[0], 1'b1);
        exec(4'h7, 8'h02, 8'h02);
        chk(status_flags[0], 1'b0);
        apb(1'b1, 8'h04, 32'hff);
        chk(status_flags, 8'hcf);
        pulse(3'b100);
        apb(1'b1, 8'h04, 32'h00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h20);
        pulse(3'b001);
        chk(status_flags[5:4], 2'b01);
        pulse(3'b100);
        chk(status_flags[5:4], 2'b11);
        pulse(3'b010);
        chk(status_flags[5:4], 2'b00);
        apb(1'b1, 8'h40, 32'hff);
        chk(er, 1'b1);
        pulse(3'b101);
        chk(status_flags[5:4], 2'b11);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk({status_flags[5:4], program_bank_select}, 3'b000);
        complete_run();
    end
endmodule
